// file: cmd_pkg.sv
// constants for the query and run-time settings command interpreter
// assumes a 32-bit AXI4-Lite master and one 200 MHz clock
package cmd_pkg;
  // register byte addresses
  localparam logic [7:0] OFS_CMD_WORD0 = 8'h00; // bytes 3..0 of a command
  localparam logic [7:0] OFS_CMD_WORD1 = 8'h04; // byte 4, write starts command
  localparam logic [7:0] OFS_RSP_WORD0 = 8'h08; // response bytes 3..0
  localparam logic [7:0] OFS_RSP_WORD1 = 8'h0C; // response bytes 7..4
  localparam logic [7:0] OFS_RSP_WORD2 = 8'h10; // response bytes 9..8
  localparam logic [7:0] OFS_SETTINGS  = 8'h14; // live settings readback
  // command codes and answer codes
  localparam logic [7:0] CODE_QUERY    = 8'h51;
  localparam logic [7:0] CODE_SETTINGS = 8'h60;
  localparam logic [7:0] CODE_OK       = 8'h00;
  localparam logic [7:0] MARK_LEVEL    = 8'hEE;
  localparam logic [7:0] MARK_DIR      = 8'hEF;
  // reset values of the volatile settings, then the bus response codes
  localparam logic [4:0] RST_CLK_DIV   = 5'h00;
  localparam logic [2:0] RST_REF_SEL   = 3'h0;
  localparam logic [4:0] RST_DAC_CODE  = 5'h00;
  localparam logic [1:0] RESP_OKAY     = 2'b00;
  localparam logic [1:0] RESP_SLVERR   = 2'b10;
  // field positions
  localparam int LOAD_BIT = 7;
endpackage

// file: cmd_engine.sv
// AXI4-Lite command interpreter: pin query and run-time settings
// assumes pins are synchronous to nothing; they pass two flops first
//
// Notes on behaviour
// - answer echoes query code, status 00
// - level bytes per pin, EE if unassigned
// - direction bytes per pin, EF if unassigned
// - settings volatile, lost at reset only
// - byte 2 bit 7 loads clock divider
// - byte 2 bits 4-3 duty cycle
// - byte 2 bits 2-0 divider value
// - byte 3 bit 7 loads reference select
// - byte 3 bits 2-1 reference level
// - byte 3 bit 0 reference source
// - byte 4 bit 7 loads output code
`timescale 1ns/100ps
module cmd_engine
  import cmd_pkg::*;
(
  // clock and reset
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_RST,
  // axi4-lite write
  input  wire logic [7:0] I_AWADDR,
  input  wire logic       I_AWVALID,
  output logic            O_AWREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0] I_WSTRB,
  input  wire logic       I_WVALID,
  output logic            O_WREADY,
  output logic [1:0]      O_BRESP,
  output logic            O_BVALID,
  input  wire logic       I_BREADY,
  // axi4-lite read
  input  wire logic [7:0] I_ARADDR,
  input  wire logic       I_ARVALID,
  output logic            O_ARREADY,
  output logic [31:0]     O_RDATA,
  output logic [1:0]      O_RRESP,
  output logic            O_RVALID,
  input  wire logic       I_RREADY,
  // general pins
  input  wire logic [3:0] I_PIN_LEVEL,
  input  wire logic [3:0] I_PIN_IS_GPIO,
  input  wire logic [3:0] I_PIN_IS_INPUT,
  // volatile settings out
  output logic [4:0]      O_CLK_DIV,
  output logic [2:0]      O_REF_SEL,
  output logic [4:0]      O_DAC_CODE
);
  import cmd_pkg::*;

  logic [31:0] cmd0_reg;
  logic [7:0]  cmd4_reg;
  logic [79:0] rsp_reg;
  logic [4:0]  clk_div_reg;
  logic [2:0]  ref_sel_reg;
  logic [4:0]  dac_code_reg;
  logic [11:0] pin_s1_reg;
  logic [11:0] pin_s2_reg;
  logic [7:0]  awaddr_reg;
  logic        aw_have_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        w_have_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        go_reg;
  // readies live in flops of their own so no output passes a gate
  logic        awready_reg;
  logic        wready_reg;
  logic        arready_reg;

  // byte-lane merge, used for both command words
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++)
      if (strb[k]) r[8*k +: 8] = nw[8*k +: 8];
    return r;
  endfunction

  // write path: address and data taken in either order
  wire do_write = aw_have_reg && w_have_reg && !bvalid_reg;
  wire hit_c0   = awaddr_reg == OFS_CMD_WORD0;
  wire hit_c1   = awaddr_reg == OFS_CMD_WORD1;
  wire [31:0] c1_merged = merge({24'h000000, cmd4_reg}, wdata_reg, wstrb_reg);

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
      cmd0_reg    <= 32'h00000000;
      cmd4_reg    <= 8'h00;
      go_reg      <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
    end
    else
    begin
      go_reg <= 1'b0;
      if (I_AWVALID && !aw_have_reg)
      begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= I_AWADDR;
        awready_reg <= 1'b0;
      end
      if (I_WVALID && !w_have_reg)
      begin
        w_have_reg <= 1'b1;
        wdata_reg  <= I_WDATA;
        wstrb_reg  <= I_WSTRB;
        wready_reg <= 1'b0;
      end
      if (do_write)
      begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        awready_reg <= 1'b1; // free again once the pair is consumed
        wready_reg  <= 1'b1;
        bresp_reg   <= (hit_c0 || hit_c1) ? RESP_OKAY : RESP_SLVERR;
        if (hit_c0) cmd0_reg <= merge(cmd0_reg, wdata_reg, wstrb_reg);
        if (hit_c1)
        begin
          cmd4_reg <= c1_merged[7:0];
          go_reg   <= 1'b1; // command runs on the word holding byte 4
        end
      end
      if (bvalid_reg && I_BREADY) bvalid_reg <= 1'b0;
    end
  end

  // pin sampling: the first stage feeds only the second
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      pin_s1_reg <= 12'h000;
      pin_s2_reg <= 12'h000;
    end
    else
    begin
      pin_s1_reg <= {I_PIN_IS_INPUT, I_PIN_IS_GPIO, I_PIN_LEVEL};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // command decode; bytes beyond 0 do not matter for the query
  wire [7:0] code     = cmd0_reg[7:0];
  wire       is_query = go_reg && code == CODE_QUERY;
  wire       is_set   = go_reg && code == CODE_SETTINGS;
  wire [7:0] sb2      = cmd0_reg[23:16];
  wire [7:0] sb3      = cmd0_reg[31:24];
  wire [7:0] sb4      = cmd4_reg;
  wire [3:0] lvl_s    = pin_s2_reg[3:0];
  wire [3:0] gpio_s   = pin_s2_reg[7:4];
  wire [3:0] inp_s    = pin_s2_reg[11:8];
  logic [79:0] rsp_next;

  // response image, two bytes per pin
  always_comb
  begin
    rsp_next = rsp_reg;
    if (is_query)
    begin
      rsp_next[7:0]  = CODE_QUERY;
      rsp_next[15:8] = CODE_OK;
      for (int p = 0; p < 4; p++)
      begin
        rsp_next[16*p+16 +: 8] = gpio_s[p] ? {7'h00, lvl_s[p]} : MARK_LEVEL;
        rsp_next[16*p+24 +: 8] = gpio_s[p] ? {7'h00, inp_s[p]} : MARK_DIR;
      end
    end
  end

  // volatile settings; reserved bits are never looked at
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      clk_div_reg  <= RST_CLK_DIV;
      ref_sel_reg  <= RST_REF_SEL;
      dac_code_reg <= RST_DAC_CODE;
      rsp_reg      <= 80'h0;
    end
    else
    begin
      rsp_reg <= rsp_next;
      if (is_set && sb2[LOAD_BIT])
        clk_div_reg <= sb2[4:0];
      if (is_set && sb3[LOAD_BIT])
        ref_sel_reg <= sb3[2:0];
      if (is_set && sb4[LOAD_BIT])
        dac_code_reg <= sb4[4:0];
    end
  end

  // read path: one read at a time
  wire [31:0] rd_mux =
    (I_ARADDR == OFS_CMD_WORD0) ? cmd0_reg :
    (I_ARADDR == OFS_CMD_WORD1) ? {24'h000000, cmd4_reg} :
    (I_ARADDR == OFS_RSP_WORD0) ? rsp_reg[31:0] :
    (I_ARADDR == OFS_RSP_WORD1) ? rsp_reg[63:32] :
    (I_ARADDR == OFS_RSP_WORD2) ? {16'h0000, rsp_reg[79:64]} :
    (I_ARADDR == OFS_SETTINGS)  ? {11'h000, dac_code_reg, 5'h00, ref_sel_reg, 3'h0, clk_div_reg} :
    32'h00000000;
  wire rd_hit = I_ARADDR <= OFS_SETTINGS && I_ARADDR[1:0] == 2'b00;

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg   <= RESP_OKAY;
      arready_reg <= 1'b1;
    end
    else if (I_ARVALID && arready_reg)
    begin
      rvalid_reg  <= 1'b1;
      arready_reg <= 1'b0; // one read at a time: closed until the data is taken
      rdata_reg   <= rd_mux;
      rresp_reg   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_reg && I_RREADY)
    begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // outputs straight from flops
  assign O_AWREADY  = awready_reg;
  assign O_WREADY   = wready_reg;
  assign O_BVALID   = bvalid_reg;
  assign O_BRESP    = bresp_reg;
  assign O_ARREADY  = arready_reg;
  assign O_RVALID   = rvalid_reg;
  assign O_RDATA    = rdata_reg;
  assign O_RRESP    = rresp_reg;
  assign O_CLK_DIV  = clk_div_reg;
  assign O_REF_SEL  = ref_sel_reg;
  assign O_DAC_CODE = dac_code_reg;

  // checks; a go pulse lasts one cycle, its results show at the next edge
  sequence s_query_go;
    go_reg && code == CODE_QUERY;
  endsequence
  sequence s_set_go;
    go_reg && code == CODE_SETTINGS;
  endsequence
  AST_ECHO: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    s_query_go |=> rsp_reg[15:0] == {CODE_OK, CODE_QUERY}) else $error("echo wrong");
  AST_MARK_LVL: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    s_query_go and !gpio_s[0] |=> rsp_reg[23:16] == MARK_LEVEL) else $error("level mark");
  AST_MARK_DIR: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    s_query_go and !gpio_s[3] |=> rsp_reg[79:72] == MARK_DIR) else $error("dir mark");
  AST_LVL_VAL: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    s_query_go and gpio_s[1] |=> rsp_reg[39:32] == {7'h00, $past(lvl_s[1])})
    else $error("level");
  AST_DIV_LOAD: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    is_set && sb2[7] |=> clk_div_reg == $past(sb2[4:0])) else $error("divider");
  AST_DIV_HOLD: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    !(is_set && sb2[7]) |=> $stable(clk_div_reg)) else $error("divider moved");
  AST_REF_HOLD: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    !(is_set && sb3[7]) |=> $stable(ref_sel_reg)) else $error("ref moved");
  AST_DAC_LOAD: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    is_set && sb4[7] |=> dac_code_reg == $past(sb4[4:0])) else $error("dac code");
  AST_QUERY_KEEP: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    is_query |=> $stable(dac_code_reg) && $stable(ref_sel_reg)) else $error("query changed");
  AST_DIR_VAL: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    s_query_go and gpio_s[2] |=> rsp_reg[63:56] == {7'h00, $past(inp_s[2])})
    else $error("direction");
  AST_MARK_DIR0: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    s_query_go and !gpio_s[0] |=> rsp_reg[31:24] == MARK_DIR)
    else $error("dir mark pin zero");
  // settings checks, one field group per rule except AST_REF_LOAD, which covers all of ref_sel_reg
  AST_DIV_VAL: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    s_set_go and sb2[7] |=> clk_div_reg[2:0] == $past(sb2[2:0]))
    else $error("divider value");
  AST_DUTY: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    s_set_go and sb2[7] |=> clk_div_reg[4:3] == $past(sb2[4:3]))
    else $error("duty code");
  AST_REF_LOAD: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    s_set_go and sb3[7] |=> ref_sel_reg == $past(sb3[2:0]))
    else $error("ref select");
  AST_REF_LVL: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    s_set_go and sb3[7] |=> ref_sel_reg[2:1] == $past(sb3[2:1]))
    else $error("ref level");
  AST_REF_SRC: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    s_set_go and sb3[7] |=> ref_sel_reg[0] == $past(sb3[0]))
    else $error("ref source");
  AST_DAC_HOLD: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
    !(is_set && sb4[7]) |=> $stable(dac_code_reg))
    else $error("dac code moved");
endmodule // cmd_engine

// file: host_model.sv
// host model: axi4-lite master that sends command packets
// assumes each task is entered just after a rising clock edge
`timescale 1ns/100ps
module host_model
  import cmd_pkg::*;
(
  // clock
  input  wire logic        i_clk,
  // write channels
  output logic [7:0]       o_awaddr,
  output logic [31:0]      o_wdata,
  output logic             o_awvalid,
  output logic             o_wvalid,
  output logic             o_bready,
  input  wire logic        i_awready,
  input  wire logic        i_wready,
  input  wire logic        i_bvalid,
  // read channels
  output logic [7:0]       o_araddr,
  output logic             o_arvalid,
  output logic             o_rready,
  input  wire logic        i_arready,
  input  wire logic        i_rvalid
);
  // idle bus until the first request
  initial
  begin
    {o_awaddr, o_wdata, o_araddr} = '0;
    {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = '0;
  end
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    o_awaddr  <= a;
    o_wdata   <= d;
    o_awvalid <= 1'b1;
    o_wvalid  <= 1'b1;
    o_bready  <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (i_awready) o_awvalid <= 1'b0;
      if (i_wready) o_wvalid <= 1'b0;
    end
    while (!i_bvalid);
    o_bready <= 1'b0;
    @(posedge i_clk); // spare edge so the next call never re-drives in this step
  endtask
  task automatic rd(input logic [7:0] a);
    o_araddr  <= a;
    o_arvalid <= 1'b1;
    o_rready  <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (i_arready) o_arvalid <= 1'b0;
    end
    while (!i_rvalid);
    o_rready <= 1'b0;
    @(posedge i_clk);
  endtask
  // code in byte 0; the word at 0x04 starts the command
  task automatic send_cmd(input logic [7:0] c, b1, b2, b3, b4);
    wr(OFS_CMD_WORD0, {b3, b2, b1, c});
    wr(OFS_CMD_WORD1, {24'h000000, b4});
  endtask
endmodule // host_model

// file: test_gpio_query_and_runtime_settings.sv
// testbench: pin queries and settings updates through the host model
// assumes the engine answers within the timeout ceiling
`timescale 1ns/100ps
module test_gpio_query_and_runtime_settings;
  import cmd_pkg::*;
  logic        clk, rst, awv, wv, br, arv, rr, awr, wr_, bv, arr, rv;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0]  bresp, rresp;
  logic [3:0]  lvl, gp, inp;
  logic [4:0]  div, dac, ex_div, ex_dac;
  logic [2:0]  rsel, ex_ref;
  logic [65:0] eq[$];
  logic [65:0] e;
  int          n_mismatch, num_checks, cyc, i;
  cmd_engine cmd_engine_inst (.I_CLK_SYS(clk), .I_RST(rst), .I_AWADDR(awa), .I_AWVALID(awv),
    .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wr_),
    .O_BRESP(bresp), .O_BVALID(bv), .I_BREADY(br), .I_ARADDR(ara), .I_ARVALID(arv),
    .O_ARREADY(arr), .O_RDATA(rdat), .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(rr),
    .I_PIN_LEVEL(lvl), .I_PIN_IS_GPIO(gp), .I_PIN_IS_INPUT(inp), .O_CLK_DIV(div),
    .O_REF_SEL(rsel), .O_DAC_CODE(dac));
  host_model host_model_inst (.i_clk(clk), .o_awaddr(awa), .o_wdata(wd), .o_awvalid(awv),
    .o_wvalid(wv), .o_bready(br), .i_awready(awr), .i_wready(wr_), .i_bvalid(bv),
    .o_araddr(ara), .o_arvalid(arv), .o_rready(rr), .i_arready(arr), .i_rvalid(rv));
  always #2.5 clk = ~clk;
  task automatic chk(input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // notes hold {resp, mask, data}; writes expect a response code only
  task automatic cmd(input logic [7:0] c, b1, b2, b3, b4);
    eq.push_back({RESP_OKAY, 64'h0});
    eq.push_back({RESP_OKAY, 64'h0});
    host_model_inst.send_cmd(c, b1, b2, b3, b4);
    repeat (4) @(posedge clk); // answer settles on the same edge that takes the write response
  endtask
  task automatic rd_exp(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d, m);
    eq.push_back({r, m, d});
    host_model_inst.rd(a);
  endtask
  // reads and checks the live settings against the running model
  task automatic chk_set();
    chk({27'h0, div}, {27'h0, ex_div});
    chk({29'h0, rsel}, {29'h0, ex_ref});
    chk({27'h0, dac}, {27'h0, ex_dac});
    chk({27'h0, awr, wr_, arr, bv, rv}, 32'h0000001C);
    rd_exp(OFS_SETTINGS, RESP_OKAY, {11'h0, ex_dac, 5'h0, ex_ref, 3'h0, ex_div}, 32'h001F071F);
  endtask
  task automatic query();
    logic [7:0] b [10];
    lvl <= 4'($urandom);
    gp  <= 4'($urandom);
    inp <= 4'($urandom);
    repeat (3) @(posedge clk); // pins pass two sync flops first
    b[0] = CODE_QUERY;
    b[1] = CODE_OK;
    for (int k = 0; k < 4; k++)
    begin
      b[2 + 2 * k] = gp[k] ? {7'h00, lvl[k]} : MARK_LEVEL;
      b[3 + 2 * k] = gp[k] ? {7'h00, inp[k]} : MARK_DIR;
    end
    cmd(CODE_QUERY, 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom));
    rd_exp(OFS_RSP_WORD0, RESP_OKAY, {b[3], b[2], b[1], b[0]}, '1);
    rd_exp(OFS_RSP_WORD1, RESP_OKAY, {b[7], b[6], b[5], b[4]}, '1);
    rd_exp(OFS_RSP_WORD2, RESP_OKAY, {16'h0, b[9], b[8]}, 32'h0000FFFF);
  endtask
  // first four passes force a load and walk every duty and level code
  task automatic settings(input int n);
    logic [7:0] b2, b3, b4;
    b2 = 8'($urandom);
    b3 = 8'($urandom);
    b4 = 8'($urandom);
    b2[4:3] = 2'(n);
    b3[2:1] = 2'(n);
    b2[7] = b2[7] | (n < 4);
    b3[7] = b3[7] | (n < 4);
    cmd(CODE_SETTINGS, 8'($urandom), b2, b3, b4);
    if (b2[LOAD_BIT]) ex_div = b2[4:0];
    if (b3[LOAD_BIT]) ex_ref = b3[2:0];
    if (b4[LOAD_BIT]) ex_dac = b4[4:0];
    chk_set();
  endtask
  // monitor: oldest note against each response handshake
  always @(posedge clk)
  begin
    if ((rv && rr) || (bv && br))
    begin
      e = eq.pop_front();
      chk({30'h0, rv ? rresp : bresp}, {30'h0, e[65:64]});
      chk(rdat & e[63:32] & {32{rv}}, e[31:0]);
    end
  end
  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    {lvl, gp, inp, ex_div, ex_ref, ex_dac} = '0;
    {n_mismatch, num_checks, cyc} = '0;
    void'($urandom(78906));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_set();
    rd_exp(8'h18, RESP_SLVERR, 32'h0, '1);
    for (i = 0; i < 8; i++) query();
    cmd(8'h77, 8'h00, 8'hFF, 8'hFF, 8'hFF);
    chk_set();
    eq.push_back({RESP_SLVERR, 64'h0});
    host_model_inst.wr(OFS_RSP_WORD0, 32'hFFFFFFFF);
    for (i = 0; i < 16; i++) settings(i);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    {ex_div, ex_ref, ex_dac} = '0;
    @(posedge clk);
    chk_set();
    close_out();
  end
endmodule // test_gpio_query_and_runtime_settings
